// ==== rtl/fpc_nv_store.sv ====
package fpc_pkg;
  typedef enum logic [1:0] {FPC_OPEN, FPC_PROTECTED, FPC_KILL} fpc_prot_t;
  typedef enum logic [1:0] {FPC_OP_READ, FPC_OP_WRITE, FPC_OP_ERASE_ROW, FPC_OP_ERASE_ALL} fpc_op_t;
  typedef enum logic [1:0] {FPC_SRC_CPU, FPC_SRC_SYS, FPC_SRC_DBG} fpc_src_t;
  typedef enum logic [1:0] {FPC_CMD_PROTECT, FPC_CMD_KILL, FPC_CMD_OPEN, FPC_CMD_ROWS} fpc_cmd_t;
  typedef enum logic [1:0] {FPC_IDLE, FPC_READ_WAIT, FPC_BUSY} fpc_fsm_t;
  localparam fpc_prot_t  FPC_SHIP_STATE      = FPC_OPEN;
  localparam logic [6:0] FPC_SLOW_SYSCLK_MHZ = 7'h18;
  localparam logic [6:0] FPC_FAST_SYSCLK_MHZ = 7'h30;
  localparam logic [1:0] FPC_WAIT_SLOW       = 2'h0;
  localparam logic [1:0] FPC_WAIT_FAST       = 2'h1;
endpackage : fpc_pkg

`timescale 1ns/1ps
module fpc_nv_store import fpc_pkg::*; #(
  parameter int ROWS = 8
) (
  input  wire logic            clock,
  input  wire logic            por_n,
  input  wire logic            boot_blank,
  input  wire fpc_prot_t       boot_state,
  input  wire logic [ROWS-1:0] boot_wp,
  input  wire logic [ROWS-1:0] boot_rp,
  input  wire logic            wr_state_en,
  input  wire fpc_prot_t       wr_state,
  input  wire logic            wr_rows_en,
  input  wire logic [ROWS-1:0] wr_wp,
  input  wire logic [ROWS-1:0] wr_rp,
  output fpc_prot_t            state_q,
  output logic [ROWS-1:0]      wp_q,
  output logic [ROWS-1:0]      rp_q,
  output logic                 persist_we
);
  typedef struct packed {
    fpc_prot_t       state;
    logic [ROWS-1:0] wp;
    logic [ROWS-1:0] rp;
    logic            we;
  } fpc_nv_t;

  fpc_nv_t s_r;
  fpc_nv_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.we = 1'b0;
    if (!por_n) begin
      s_nxt.state = boot_blank ? FPC_SHIP_STATE : boot_state;
      s_nxt.wp    = boot_blank ? '0 : boot_wp;
      s_nxt.rp    = boot_blank ? '0 : boot_rp;
    end else begin
      if (wr_state_en && s_r.state != FPC_KILL) begin
        s_nxt.state = wr_state;
        s_nxt.we    = 1'b1;
      end
      if (wr_rows_en) begin
        s_nxt.wp = wr_wp;
        s_nxt.rp = wr_rp;
        s_nxt.we = 1'b1;
      end
    end
  end

  // Deliberately untouched by the system reset; only power-on reloads it
  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  assign state_q    = s_r.state;
  assign wp_q       = s_r.wp;
  assign rp_q       = s_r.rp;
  assign persist_we = s_r.we;
endmodule : fpc_nv_store

// ==== rtl/fpc_flash_protect_ctrl.sv ====
`timescale 1ns/1ps
module fpc_flash_protect_ctrl import fpc_pkg::*; #(
  parameter int ROWS = 8,
  parameter int RW   = $clog2(ROWS)
) (
  input  wire logic            clock,
  input  wire logic            rstn,
  input  wire logic            por_n,
  input  wire logic            boot_blank,
  input  wire fpc_prot_t       boot_state,
  input  wire logic [ROWS-1:0] boot_wp,
  input  wire logic [ROWS-1:0] boot_rp,
  input  wire logic [6:0]      sysclk_mhz,
  input  wire logic            cmd_valid,
  input  wire fpc_cmd_t        cmd_code,
  input  wire logic [ROWS-1:0] cmd_wp,
  input  wire logic [ROWS-1:0] cmd_rp,
  output logic                 cmd_done,
  output logic                 cmd_rejected,
  input  wire logic            acc_valid,
  input  wire fpc_src_t        acc_src,
  input  wire fpc_op_t         acc_op,
  input  wire logic [RW-1:0]   acc_row,
  output logic                 acc_ready,
  output logic                 acc_done,
  output logic                 acc_denied,
  output logic                 fl_start,
  output fpc_op_t              fl_op,
  output logic [RW-1:0]        fl_row,
  input  wire logic            fl_done,
  output logic [1:0]           flash_wait_cycles,
  output logic                 dbg_port_enable,
  output fpc_prot_t            prot_state,
  output logic [ROWS-1:0]      row_wp,
  output logic [ROWS-1:0]      row_rp,
  output logic                 persist_we
);
  typedef struct packed {
    fpc_fsm_t      fsm;
    logic [1:0]    cnt;
    fpc_op_t       op;
    logic          erased;
    logic [1:0]    ws;
    logic          done;
    logic          denied;
    logic          fl_start;
    fpc_op_t       fl_op;
    logic [RW-1:0] fl_row;
    logic          cmd_done;
    logic          cmd_rej;
  } fpc_ctrl_t;

  fpc_ctrl_t s_r;
  fpc_ctrl_t s_nxt;

  logic            wr_state_en;
  fpc_prot_t       wr_state;
  logic            wr_rows_en;
  logic            take;
  logic            allow;
  logic            cmd_ok;

  fpc_nv_store #(
    .ROWS (ROWS)
  ) u_store (
    .clock       (clock),
    .por_n       (por_n),
    .boot_blank  (boot_blank),
    .boot_state  (boot_state),
    .boot_wp     (boot_wp),
    .boot_rp     (boot_rp),
    .wr_state_en (wr_state_en),
    .wr_state    (wr_state),
    .wr_rows_en  (wr_rows_en),
    .wr_wp       (cmd_wp),
    .wr_rp       (cmd_rp),
    .state_q     (prot_state),
    .wp_q        (row_wp),
    .rp_q        (row_rp),
    .persist_we  (persist_we)
  );

  assign take      = acc_valid && acc_ready;
  assign acc_ready = (s_r.fsm == FPC_IDLE);

  assign dbg_port_enable = (prot_state == FPC_OPEN);

  // Command decision: only the three legal moves change the state
  always_comb begin
    cmd_ok      = 1'b0;
    wr_state_en = 1'b0;
    wr_state    = prot_state;
    wr_rows_en  = 1'b0;
    if (cmd_valid) begin
      case (cmd_code)
        FPC_CMD_PROTECT: cmd_ok = (prot_state == FPC_OPEN);
        FPC_CMD_KILL:    cmd_ok = (prot_state == FPC_OPEN);
        FPC_CMD_OPEN:    cmd_ok = (prot_state == FPC_PROTECTED) && s_r.erased;
        FPC_CMD_ROWS:    cmd_ok = 1'b1;
        default:         cmd_ok = 1'b0;
      endcase
      if (cmd_ok && cmd_code != FPC_CMD_ROWS) begin
        wr_state_en = 1'b1;
        case (cmd_code)
          FPC_CMD_PROTECT: wr_state = FPC_PROTECTED;
          FPC_CMD_KILL:    wr_state = FPC_KILL;
          default:         wr_state = FPC_OPEN;
        endcase
      end
      wr_rows_en = cmd_ok && (cmd_code == FPC_CMD_ROWS);
    end
  end

  // Access decision per source
  always_comb begin
    allow = 1'b0;
    case (acc_src)
      FPC_SRC_SYS: allow = 1'b1;
      FPC_SRC_DBG: begin
        if (prot_state == FPC_OPEN) begin
          allow = 1'b1;
        end else if (prot_state == FPC_PROTECTED) begin
          allow = (acc_op == FPC_OP_ERASE_ALL);
        end else begin
          allow = 1'b0;
        end
      end
      default: allow = 1'b1;
    endcase
    if (acc_src != FPC_SRC_SYS) begin
      if (acc_op == FPC_OP_READ && row_rp[acc_row]) begin
        allow = 1'b0;
      end else if ((acc_op == FPC_OP_WRITE || acc_op == FPC_OP_ERASE_ROW) && row_wp[acc_row]) begin
        allow = 1'b0;
      end
    end
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.done     = 1'b0;
    s_nxt.denied   = 1'b0;
    s_nxt.fl_start = 1'b0;
    s_nxt.cmd_done = cmd_valid;
    s_nxt.cmd_rej  = cmd_valid && !cmd_ok;
    s_nxt.ws = (sysclk_mhz > FPC_SLOW_SYSCLK_MHZ) ? FPC_WAIT_FAST : FPC_WAIT_SLOW;
    // Forget an old erase on entry, unless an erase-all finishes in that same cycle, so a fresh one is needed
    if (wr_state_en && wr_state == FPC_PROTECTED) begin
      s_nxt.erased = 1'b0;
    end
    case (s_r.fsm)
      FPC_IDLE: begin
        if (take) begin
          if (!allow) begin
            s_nxt.denied = 1'b1;
          end else if (acc_op == FPC_OP_READ) begin
            // Zero wait states: answer next cycle and stay ready
            if (s_r.ws == 2'h0) begin
              s_nxt.done = 1'b1;
            end else begin
              s_nxt.fsm = FPC_READ_WAIT;
              s_nxt.cnt = s_r.ws - 2'h1;
            end
          end else begin
            s_nxt.fsm      = FPC_BUSY;
            s_nxt.op       = acc_op;
            s_nxt.fl_start = 1'b1;
            s_nxt.fl_op    = acc_op;
            s_nxt.fl_row   = acc_row;
            if (acc_op == FPC_OP_WRITE) begin
              s_nxt.erased = 1'b0;
            end
          end
        end
      end
      FPC_READ_WAIT: begin
        if (s_r.cnt == 2'h0) begin
          s_nxt.fsm  = FPC_IDLE;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 2'h1;
        end
      end
      FPC_BUSY: begin
        if (fl_done) begin
          s_nxt.fsm  = FPC_IDLE;
          s_nxt.done = 1'b1;
          if (s_r.op == FPC_OP_ERASE_ALL) begin
            s_nxt.erased = 1'b1;
          end
        end
      end
      default: s_nxt.fsm = FPC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_r <= '{fsm: FPC_IDLE, cnt: 2'h0, op: FPC_OP_READ, erased: 1'b0, ws: FPC_WAIT_SLOW, done: 1'b0,
               denied: 1'b0, fl_start: 1'b0, fl_op: FPC_OP_READ, fl_row: '0, cmd_done: 1'b0, cmd_rej: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc_done          = s_r.done;
  assign acc_denied        = s_r.denied;
  assign fl_start          = s_r.fl_start;
  assign fl_op             = s_r.fl_op;
  assign fl_row            = s_r.fl_row;
  assign cmd_done          = s_r.cmd_done;
  assign cmd_rejected      = s_r.cmd_rej;
  assign flash_wait_cycles = s_r.ws;

  a_blank_ships_open: assert property (@(posedge clock)
    !por_n && boot_blank |=> prot_state == FPC_OPEN && dbg_port_enable)
    else $error("blank part did not come up open");

  a_protect_from_open: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    cmd_valid && cmd_code == FPC_CMD_PROTECT && prot_state == FPC_OPEN
    |=> prot_state == FPC_PROTECTED && cmd_done && !cmd_rejected)
    else $error("open to protected not taken");

  a_dbg_protect_deny: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    take && acc_src == FPC_SRC_DBG && prot_state == FPC_PROTECTED && acc_op != FPC_OP_ERASE_ALL
    |=> acc_denied && !fl_start && !acc_done)
    else $error("debug access served while protected");

  a_open_needs_erase: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    $past(prot_state) == FPC_PROTECTED && prot_state == FPC_OPEN |-> $past(s_r.erased))
    else $error("protected left without full erase");

  a_kill_from_open: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    cmd_valid && cmd_code == FPC_CMD_KILL && prot_state == FPC_OPEN |=> prot_state == FPC_KILL ##1 !dbg_port_enable)
    else $error("open to kill not taken");

  a_kill_port_off: assert property (@(posedge clock) disable iff (!rstn)
    prot_state == FPC_KILL |-> !dbg_port_enable)
    else $error("debug port enabled in kill");

  a_kill_no_erase: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    take && acc_src == FPC_SRC_DBG && prot_state == FPC_KILL |=> acc_denied && !fl_start)
    else $error("external request served in kill");

  a_kill_is_final: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    prot_state == FPC_KILL |=> prot_state == FPC_KILL)
    else $error("kill state was left");

  a_row_write_block: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    take && acc_src == FPC_SRC_CPU && acc_op == FPC_OP_WRITE && row_wp[acc_row] |=> acc_denied && !fl_start)
    else $error("write to protected row served");

  a_sys_always_served: assert property (@(posedge clock) disable iff (!rstn)
    take && acc_src == FPC_SRC_SYS |=> !acc_denied)
    else $error("system call access refused");

  a_fast_read_wait: assert property (@(posedge clock) disable iff (!rstn)
    take && acc_src == FPC_SRC_SYS && acc_op == FPC_OP_READ && flash_wait_cycles == FPC_WAIT_FAST
    |=> !acc_done ##1 acc_done)
    else $error("read at 48 MHz not one wait state");

  a_slow_read_wait: assert property (@(posedge clock) disable iff (!rstn)
    take && acc_src == FPC_SRC_SYS && acc_op == FPC_OP_READ && flash_wait_cycles == FPC_WAIT_SLOW |=> acc_done)
    else $error("read at 24 MHz not zero wait");

  a_illegal_move: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    cmd_valid && cmd_code != FPC_CMD_ROWS && prot_state != FPC_OPEN
    && !(cmd_code == FPC_CMD_OPEN && prot_state == FPC_PROTECTED && s_r.erased)
    |=> cmd_rejected && prot_state == $past(prot_state))
    else $error("illegal state move accepted");

  a_state_survives: assert property (@(posedge clock) disable iff (!por_n)
    !rstn && !wr_state_en |=> prot_state == $past(prot_state))
    else $error("system reset changed protection state");

  a_persist_on_cmd: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    cmd_valid |=> persist_we == !cmd_rejected)
    else $error("store save strobe does not match command outcome");

  a_read_no_flash: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    take && acc_op == FPC_OP_READ |=> !fl_start)
    else $error("read started a flash program cycle");

  a_open_dbg_served: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    take && acc_src == FPC_SRC_DBG && prot_state == FPC_OPEN && !row_rp[acc_row] && !row_wp[acc_row]
    |=> !acc_denied)
    else $error("debug access refused while open");

  a_erase_rec_clear: assert property (@(posedge clock) disable iff (!rstn || !por_n)
    cmd_valid && cmd_code == FPC_CMD_PROTECT && prot_state == FPC_OPEN
    && !(s_r.fsm == FPC_BUSY && fl_done) |=> !s_r.erased)
    else $error("old erase kept on entering protected");
endmodule : fpc_flash_protect_ctrl

// ==== bench/fpc_flash_model.sv ====
`timescale 1ns/1ps
module fpc_flash_model (
  input  wire logic       clock,
  input  wire logic       fl_start,
  input  wire logic [3:0] delay,
  output logic            fl_done
);
  logic [3:0] cnt_r;
  logic       busy_r;
  // Variable answer time so both quick and slow program cycles are seen
  always @(posedge clock) begin
    fl_done <= 1'b0;
    if (fl_start === 1'b1) begin
      busy_r <= 1'b1;
      cnt_r  <= delay;
    end else if (busy_r === 1'b1) begin
      if (cnt_r == 4'h0) begin
        fl_done <= 1'b1;
        busy_r  <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : fpc_flash_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench import fpc_pkg::*;;
  logic       clock, rstn, por_n, boot_blank, cmd_valid, cmd_done, cmd_rejected, acc_valid, acc_ready;
  logic       acc_done, acc_denied, fl_start, fl_done, dbg_port_enable, persist_we;
  logic [7:0] boot_wp, boot_rp, cmd_wp, cmd_rp, row_wp, row_rp;
  logic [6:0] sysclk_mhz;
  logic [2:0] acc_row, fl_row;
  logic [1:0] flash_wait_cycles;
  logic [3:0] fl_delay;
  fpc_prot_t  boot_state, prot_state;
  fpc_cmd_t   cmd_code;
  fpc_src_t   acc_src;
  fpc_op_t    acc_op, fl_op;
  int         err_count, cmp_count;

  fpc_flash_protect_ctrl u_fpc_flash_protect_ctrl (.clock(clock), .rstn(rstn), .por_n(por_n),
    .boot_blank(boot_blank), .boot_state(boot_state), .boot_wp(boot_wp), .boot_rp(boot_rp),
    .sysclk_mhz(sysclk_mhz), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wp(cmd_wp), .cmd_rp(cmd_rp),
    .cmd_done(cmd_done), .cmd_rejected(cmd_rejected), .acc_valid(acc_valid), .acc_src(acc_src),
    .acc_op(acc_op), .acc_row(acc_row), .acc_ready(acc_ready), .acc_done(acc_done), .acc_denied(acc_denied),
    .fl_start(fl_start), .fl_op(fl_op), .fl_row(fl_row), .fl_done(fl_done),
    .flash_wait_cycles(flash_wait_cycles), .dbg_port_enable(dbg_port_enable), .prot_state(prot_state),
    .row_wp(row_wp), .row_rp(row_rp), .persist_we(persist_we));
  fpc_flash_model u_fpc_flash_model (.clock(clock), .fl_start(fl_start), .delay(fl_delay), .fl_done(fl_done));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic do_cmd(input fpc_cmd_t c, input logic [7:0] wp, input logic [7:0] rp, input logic rej,
                        input fpc_prot_t st);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_wp    <= wp;
    cmd_rp    <= rp;
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    chk({cmd_done, cmd_rejected, persist_we, prot_state, dbg_port_enable}, {1'b1, rej, !rej, st, st == FPC_OPEN});
  endtask : do_cmd

  task automatic do_acc(input fpc_src_t s, input fpc_op_t o, input logic [2:0] r, input logic den);
    int   n;
    logic seen;
    logic ws;
    n    = 0;
    seen = 1'b0;
    ws   = sysclk_mhz > FPC_SLOW_SYSCLK_MHZ;
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_src   <= s;
    acc_op    <= o;
    acc_row   <= r;
    @(posedge clock);
    acc_valid <= 1'b0;
    while (!seen && n < 40) begin
      @(negedge clock);
      n++;
      if (n == 1 && !den && o != FPC_OP_READ) chk({fl_start, fl_op, fl_row}, {1'b1, o, r});
      if (n == 1) chk(acc_ready, den || (o == FPC_OP_READ && !ws));
      seen = (acc_done === 1'b1) || (acc_denied === 1'b1);
    end
    if (!seen) begin
      err_count++;
      final_report();
    end
    chk(acc_denied, den);
    if (den) chk(16'(n), 16'h0001);
    else if (o == FPC_OP_READ) chk(16'(n), 16'(1 + ws));
  endtask : do_acc

  task automatic t_ship;
    chk({prot_state, dbg_port_enable}, {FPC_OPEN, 1'b1});
    do_acc(FPC_SRC_DBG, FPC_OP_READ, 3'h5, 1'b0);
    do_acc(FPC_SRC_DBG, FPC_OP_WRITE, 3'h5, 1'b0);
  endtask : t_ship

  task automatic t_wait;
    chk(flash_wait_cycles, FPC_WAIT_SLOW);
    do_acc(FPC_SRC_CPU, FPC_OP_READ, 3'h0, 1'b0);
    @(posedge clock);
    sysclk_mhz <= FPC_FAST_SYSCLK_MHZ;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(flash_wait_cycles, FPC_WAIT_FAST);
    do_acc(FPC_SRC_CPU, FPC_OP_READ, 3'h0, 1'b0);
  endtask : t_wait

  task automatic t_rows;
    do_cmd(FPC_CMD_ROWS, 8'h04, 8'h08, 1'b0, FPC_OPEN);
    chk({row_wp, row_rp}, 16'h0408);
    do_acc(FPC_SRC_CPU, FPC_OP_WRITE, 3'h2, 1'b1);
    do_acc(FPC_SRC_CPU, FPC_OP_ERASE_ROW, 3'h2, 1'b1);
    do_acc(FPC_SRC_DBG, FPC_OP_READ, 3'h3, 1'b1);
    do_acc(FPC_SRC_CPU, FPC_OP_READ, 3'h2, 1'b0);
    do_acc(FPC_SRC_CPU, FPC_OP_WRITE, 3'h3, 1'b0);
    do_acc(FPC_SRC_SYS, FPC_OP_WRITE, 3'h2, 1'b0);
    do_acc(FPC_SRC_SYS, FPC_OP_READ, 3'h3, 1'b0);
    do_cmd(FPC_CMD_ROWS, 8'h00, 8'h00, 1'b0, FPC_OPEN);
  endtask : t_rows

  task automatic t_protect;
    do_cmd(FPC_CMD_OPEN, 8'h00, 8'h00, 1'b1, FPC_OPEN);
    do_cmd(FPC_CMD_PROTECT, 8'h00, 8'h00, 1'b0, FPC_PROTECTED);
    do_acc(FPC_SRC_DBG, FPC_OP_READ, 3'h1, 1'b1);
    do_acc(FPC_SRC_DBG, FPC_OP_WRITE, 3'h1, 1'b1);
    do_acc(FPC_SRC_CPU, FPC_OP_READ, 3'h1, 1'b0);
    do_cmd(FPC_CMD_OPEN, 8'h00, 8'h00, 1'b1, FPC_PROTECTED);
    do_cmd(FPC_CMD_KILL, 8'h00, 8'h00, 1'b1, FPC_PROTECTED);
    do_cmd(FPC_CMD_PROTECT, 8'h00, 8'h00, 1'b1, FPC_PROTECTED);
    fl_delay <= 4'h9;
    do_acc(FPC_SRC_DBG, FPC_OP_ERASE_ALL, 3'h0, 1'b0);
    do_acc(FPC_SRC_SYS, FPC_OP_WRITE, 3'h0, 1'b0);
    do_cmd(FPC_CMD_OPEN, 8'h00, 8'h00, 1'b1, FPC_PROTECTED);
    do_acc(FPC_SRC_SYS, FPC_OP_ERASE_ALL, 3'h0, 1'b0);
    do_cmd(FPC_CMD_OPEN, 8'h00, 8'h00, 1'b0, FPC_OPEN);
    fl_delay <= 4'h0;
  endtask : t_protect

  task automatic t_kill;
    do_cmd(FPC_CMD_KILL, 8'h00, 8'h00, 1'b0, FPC_KILL);
    do_acc(FPC_SRC_DBG, FPC_OP_READ, 3'h4, 1'b1);
    do_acc(FPC_SRC_DBG, FPC_OP_WRITE, 3'h4, 1'b1);
    do_acc(FPC_SRC_DBG, FPC_OP_ERASE_ALL, 3'h0, 1'b1);
    do_acc(FPC_SRC_SYS, FPC_OP_READ, 3'h4, 1'b0);
    do_acc(FPC_SRC_SYS, FPC_OP_ERASE_ROW, 3'h4, 1'b0);
    do_acc(FPC_SRC_SYS, FPC_OP_ERASE_ALL, 3'h0, 1'b0);
    do_cmd(FPC_CMD_OPEN, 8'h00, 8'h00, 1'b1, FPC_KILL);
    do_cmd(FPC_CMD_PROTECT, 8'h00, 8'h00, 1'b1, FPC_KILL);
    do_cmd(FPC_CMD_KILL, 8'h00, 8'h00, 1'b1, FPC_KILL);
  endtask : t_kill

  task automatic t_retain;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    chk({prot_state, dbg_port_enable}, {FPC_KILL, 1'b0});
    @(posedge clock);
    por_n      <= 1'b0;
    boot_blank <= 1'b0;
    boot_state <= FPC_PROTECTED;
    boot_wp    <= 8'hA5;
    boot_rp    <= 8'h5A;
    repeat (2) @(posedge clock);
    por_n <= 1'b1;
    @(negedge clock);
    chk(prot_state, FPC_PROTECTED);
    chk({row_wp, row_rp}, 16'hA55A);
  endtask : t_retain

  initial begin
    err_count  = 0;
    cmp_count  = 0;
    rstn       = 1'b0;
    por_n      = 1'b0;
    boot_blank = 1'b1;
    boot_state = FPC_KILL;
    boot_wp    = 8'hFF;
    boot_rp    = 8'hFF;
    sysclk_mhz = FPC_SLOW_SYSCLK_MHZ;
    cmd_valid  = 1'b0;
    cmd_code   = FPC_CMD_ROWS;
    cmd_wp     = 8'h00;
    cmd_rp     = 8'h00;
    acc_valid  = 1'b0;
    acc_src    = FPC_SRC_CPU;
    acc_op     = FPC_OP_READ;
    acc_row    = 3'h0;
    fl_delay   = 4'h0;
    repeat (16) @(posedge clock);
    rstn  <= 1'b1;
    por_n <= 1'b1;
    @(negedge clock);
    t_ship();
    t_wait();
    t_rows();
    t_protect();
    t_kill();
    t_retain();
    final_report();
  end
endmodule : testbench
